// [verilog/lag_params.svh]
// constants for the load address generation block
// assumes inclusion by lag_pkg and the design modules of this block
// What this block does
// - immediate mode: base plus sign-extended displacement
// - immediate mode: base zero adds zero
// - indexed mode: base plus index register
// - indexed base zero: index, string forms zero
// - indirect mode: base directly, zero gives zero
// - load element at address into destination
// - update load writes address into base
// - update with base zero, or update load with base equal dest, invalid
// - big-endian byte ordering into registers
// - issue and translate in program order
// - byte zero load clears upper bits
// - algebraic half load sign-fills upper bits
`ifndef LAG_PARAMS_SVH
`define LAG_PARAMS_SVH
`define LAG_ADDR_W 32
`define LAG_DISP_W 16
`define LAG_SEL_W 5
`define LAG_DATA_W 64
`define LAG_OFF_W 3
`define LAG_BYTE_W 8
`define LAG_HALF_W 16
`define LAG_WORD_W 32
`define LAG_ZERO_SEL 5'h00
`define LAG_ADDR_RST 32'h0000_0000
`define LAG_DATA_RST 64'h0000_0000_0000_0000
`define LAG_LANES 4'h8
`endif

// [verilog/lag_pkg.sv]
// types shared by the load address generation block
// assumes lag_params.svh is on the include path
`include "lag_params.svh"
package lag_pkg;
   typedef enum logic [1:0] {
      LAG_MODE_IMM = 2'h0,
      LAG_MODE_IDX = 2'h1,
      LAG_MODE_IND = 2'h2
   } lag_mode_t;
   typedef enum logic [1:0] {
      LAG_SZ_BYTE = 2'h0,
      LAG_SZ_HALF = 2'h1,
      LAG_SZ_WORD = 2'h2,
      LAG_SZ_DWORD = 2'h3
   } lag_size_t;
   typedef enum logic [2:0] {
      LAG_ST_IDLE = 3'h1,
      LAG_ST_ISSUE = 3'h2,
      LAG_ST_WAIT = 3'h4
   } lag_state_t;
endpackage : lag_pkg

// [verilog/lag_load_align.sv]
// load data steering: picks the element out of a big-endian doubleword beat
// assumes the element does not cross the doubleword; misalignment is caught upstream
`timescale 1ns/10ps
`default_nettype none
`include "lag_params.svh"
module lag_load_align (
   input wire logic [`LAG_DATA_W-1:0] rdata_in,
   input wire logic [`LAG_OFF_W-1:0] off_in,
   input wire lag_pkg::lag_size_t size_in,
   input wire logic sign_in,
   output logic [`LAG_DATA_W-1:0] data_out
);
   import lag_pkg::*;

   function automatic logic [`LAG_DATA_W-1:0] lag_steer(
      input logic [`LAG_DATA_W-1:0] rd,
      input logic [`LAG_OFF_W-1:0] off,
      input lag_size_t sz,
      input logic sgn
   );
      logic [3:0] nbytes;
      logic [3:0] rest;
      logic [5:0] shamt;
      logic [`LAG_DATA_W-1:0] s;
      nbytes = 4'h1;
      case (sz)
         LAG_SZ_BYTE: nbytes = 4'h1;
         LAG_SZ_HALF: nbytes = 4'h2;
         LAG_SZ_WORD: nbytes = 4'h4;
         default: nbytes = `LAG_LANES;
      endcase
      // byte 0 of the beat sits in the top lane, so shift the element down
      rest = `LAG_LANES - nbytes - {1'b0, off};
      shamt = {rest[2:0], 3'h0};
      s = rd >> shamt;
      case (sz)
         LAG_SZ_BYTE: lag_steer = {{(`LAG_DATA_W-`LAG_BYTE_W){1'b0}},
                                   s[`LAG_BYTE_W-1:0]};
         LAG_SZ_HALF: lag_steer = {{(`LAG_DATA_W-`LAG_HALF_W){sgn & s[`LAG_HALF_W-1]}},
                                   s[`LAG_HALF_W-1:0]};
         LAG_SZ_WORD: lag_steer = {{(`LAG_DATA_W-`LAG_WORD_W){1'b0}},
                                   s[`LAG_WORD_W-1:0]};
         default: lag_steer = s;
      endcase
   endfunction : lag_steer

   always_comb begin
      data_out = lag_steer(rdata_in, off_in, size_in, sign_in);
   end
endmodule : lag_load_align
`default_nettype wire

// [verilog/lag_top.sv]
// load address generation: effective address, memory request and load write-back
// assumes decoder and register file on mclk_in; one access in flight at a time
`timescale 1ns/10ps
`default_nettype none
`include "lag_params.svh"
module lag_top (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire lag_pkg::lag_mode_t mode_in,
   input wire lag_pkg::lag_size_t size_in,
   input wire logic sign_in,
   input wire logic update_in,
   input wire logic store_in,
   input wire logic string_in,
   input wire logic [`LAG_SEL_W-1:0] base_gpr_sel_in,
   input wire logic [`LAG_SEL_W-1:0] index_gpr_sel_in,
   input wire logic [`LAG_SEL_W-1:0] dest_sel_in,
   input wire logic [`LAG_DISP_W-1:0] disp_in,
   input wire logic [`LAG_ADDR_W-1:0] base_gpr_in,
   input wire logic [`LAG_ADDR_W-1:0] index_gpr_in,
   input wire logic [`LAG_DATA_W-1:0] store_data_in,
   output logic mem_req_valid_out,
   input wire logic mem_req_ready_in,
   output logic [`LAG_ADDR_W-1:0] mem_addr_out,
   output lag_pkg::lag_size_t mem_size_out,
   output logic mem_we_out,
   output logic [`LAG_DATA_W-1:0] mem_wdata_out,
   input wire logic mem_rvalid_in,
   input wire logic [`LAG_DATA_W-1:0] mem_rdata_in,
   output logic wb_valid_out,
   output logic [`LAG_SEL_W-1:0] wb_dest_out,
   output logic [`LAG_DATA_W-1:0] wb_data_out,
   output logic upd_valid_out,
   output logic [`LAG_SEL_W-1:0] upd_dest_out,
   output logic [`LAG_ADDR_W-1:0] upd_data_out,
   output logic invalid_out
);
   import lag_pkg::*;

   logic rst_meta_q;
   logic rst_sync_n_q;
   lag_state_t state_q;
   logic accept;
   logic bad_form;
   logic [`LAG_ADDR_W-1:0] ea;
   logic [`LAG_ADDR_W-1:0] ea_q;
   lag_size_t size_q;
   logic sign_q;
   logic we_q;
   logic upd_q;
   logic [`LAG_SEL_W-1:0] base_sel_q;
   logic [`LAG_SEL_W-1:0] dest_q;
   logic [`LAG_DATA_W-1:0] wdata_q;
   logic [`LAG_DATA_W-1:0] load_data;

   // reset release passes two flops; assertion stays asynchronous
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   function automatic logic [`LAG_ADDR_W-1:0] lag_sext(input logic [`LAG_DISP_W-1:0] d);
      lag_sext = {{(`LAG_ADDR_W-`LAG_DISP_W){d[`LAG_DISP_W-1]}}, d};
   endfunction : lag_sext

   // base operand, zero when the base field names gpr_zero
   function automatic logic [`LAG_ADDR_W-1:0] lag_base_or_zero(
      input logic [`LAG_SEL_W-1:0] sel,
      input logic [`LAG_ADDR_W-1:0] val
   );
      lag_base_or_zero = (sel == `LAG_ZERO_SEL) ? `LAG_ADDR_RST : val;
   endfunction : lag_base_or_zero

   // carry out of the top bit is dropped by the sized result
   function automatic logic [`LAG_ADDR_W-1:0] lag_add(
      input logic [`LAG_ADDR_W-1:0] a,
      input logic [`LAG_ADDR_W-1:0] b
   );
      lag_add = a + b;
   endfunction : lag_add

   always_comb begin
      case (mode_in)
         LAG_MODE_IMM: ea = lag_add(lag_base_or_zero(base_gpr_sel_in, base_gpr_in),
                                    lag_sext(disp_in));
         LAG_MODE_IDX: begin
            if (string_in && base_gpr_sel_in == `LAG_ZERO_SEL) begin
               ea = `LAG_ADDR_RST;
            end else begin
               ea = lag_add(lag_base_or_zero(base_gpr_sel_in, base_gpr_in),
                            index_gpr_in);
            end
         end
         default: ea = lag_base_or_zero(base_gpr_sel_in, base_gpr_in);
      endcase
   end

   // update forms need a real base; loads must not also target it
   always_comb begin
      bad_form = update_in && (base_gpr_sel_in == `LAG_ZERO_SEL ||
                 (!store_in && base_gpr_sel_in == dest_sel_in));
   end

   // only one access in flight keeps issue and translation in order
   assign req_ready_out = (state_q == LAG_ST_IDLE);
   assign accept = ce_in && req_valid_in && req_ready_out;
   assign mem_req_valid_out = (state_q == LAG_ST_ISSUE);

   always_ff @(posedge mclk_in or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         state_q <= LAG_ST_IDLE;
      end else if (ce_in) begin
         case (state_q)
            LAG_ST_IDLE: begin
               if (accept && !bad_form) begin
                  state_q <= LAG_ST_ISSUE;
               end
            end
            LAG_ST_ISSUE: begin
               if (mem_req_ready_in) begin
                  state_q <= we_q ? LAG_ST_IDLE : LAG_ST_WAIT;
               end
            end
            LAG_ST_WAIT: begin
               if (mem_rvalid_in) begin
                  state_q <= LAG_ST_IDLE;
               end
            end
            default: state_q <= LAG_ST_IDLE;
         endcase
      end
   end

   // request capture; held stable while the memory side stalls
   always_ff @(posedge mclk_in or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         ea_q <= `LAG_ADDR_RST;
         size_q <= LAG_SZ_BYTE;
         sign_q <= 1'b0;
         we_q <= 1'b0;
         upd_q <= 1'b0;
         base_sel_q <= `LAG_ZERO_SEL;
         dest_q <= `LAG_ZERO_SEL;
         wdata_q <= `LAG_DATA_RST;
      end else if (accept && !bad_form) begin
         ea_q <= ea;
         size_q <= size_in;
         sign_q <= sign_in;
         we_q <= store_in;
         upd_q <= update_in;
         base_sel_q <= base_gpr_sel_in;
         dest_q <= dest_sel_in;
         wdata_q <= store_data_in;
      end
   end

   assign mem_addr_out = ea_q;
   assign mem_size_out = size_q;
   assign mem_we_out = we_q;
   assign mem_wdata_out = wdata_q;

   lag_load_align u_align (
      .rdata_in(mem_rdata_in),
      .off_in(ea_q[`LAG_OFF_W-1:0]),
      .size_in(size_q),
      .sign_in(sign_q),
      .data_out(load_data)
   );

   // load result write-back
   always_ff @(posedge mclk_in or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         wb_valid_out <= 1'b0;
         wb_dest_out <= `LAG_ZERO_SEL;
         wb_data_out <= `LAG_DATA_RST;
      end else if (ce_in) begin
         wb_valid_out <= (state_q == LAG_ST_WAIT) && mem_rvalid_in;
         if ((state_q == LAG_ST_WAIT) && mem_rvalid_in) begin
            wb_dest_out <= dest_q;
            wb_data_out <= load_data;
         end
      end
   end

   // address write-back to the base register for update forms
   always_ff @(posedge mclk_in or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         upd_valid_out <= 1'b0;
         upd_dest_out <= `LAG_ZERO_SEL;
         upd_data_out <= `LAG_ADDR_RST;
      end else if (ce_in) begin
         upd_valid_out <= upd_q && (((state_q == LAG_ST_WAIT) && mem_rvalid_in) ||
                          ((state_q == LAG_ST_ISSUE) && mem_req_ready_in && we_q));
         upd_dest_out <= base_sel_q;
         upd_data_out <= ea_q;
      end
   end

   // invalid forms are flagged and never reach memory
   always_ff @(posedge mclk_in or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         invalid_out <= 1'b0;
      end else if (ce_in) begin
         invalid_out <= accept && bad_form;
      end
   end

   property p_imm_ea;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      accept && !bad_form && mode_in == LAG_MODE_IMM && base_gpr_sel_in != `LAG_ZERO_SEL
      |=> mem_addr_out == $past(base_gpr_in) + {{16{$past(disp_in[15])}}, $past(disp_in)};
   endproperty
   a_imm_ea: assert property (p_imm_ea) else $error("immediate address wrong");

   property p_imm_zero;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      accept && !bad_form && mode_in == LAG_MODE_IMM && base_gpr_sel_in == `LAG_ZERO_SEL
      |=> mem_addr_out == {{16{$past(disp_in[15])}}, $past(disp_in)};
   endproperty
   a_imm_zero: assert property (p_imm_zero) else $error("zero base not used");

   property p_idx_ea;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      accept && !bad_form && mode_in == LAG_MODE_IDX && base_gpr_sel_in != `LAG_ZERO_SEL
      |=> mem_addr_out == $past(base_gpr_in) + $past(index_gpr_in);
   endproperty
   a_idx_ea: assert property (p_idx_ea) else $error("indexed address wrong");

   property p_idx_zero;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      accept && !bad_form && mode_in == LAG_MODE_IDX && base_gpr_sel_in == `LAG_ZERO_SEL
      |=> mem_addr_out == ($past(string_in) ? 32'h0 : $past(index_gpr_in));
   endproperty
   a_idx_zero: assert property (p_idx_zero) else $error("indexed zero base wrong");

   property p_ind_ea;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      accept && !bad_form && mode_in == LAG_MODE_IND
      |=> mem_addr_out == ($past(base_gpr_sel_in) == 5'h0 ? 32'h0 : $past(base_gpr_in));
   endproperty
   a_ind_ea: assert property (p_ind_ea) else $error("indirect address wrong");

   property p_wb;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      ce_in && state_q == LAG_ST_WAIT && mem_rvalid_in |=> wb_valid_out && wb_dest_out == dest_q;
   endproperty
   a_wb: assert property (p_wb) else $error("load data not written back");

   property p_upd;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      upd_valid_out |-> upd_data_out == mem_addr_out && upd_dest_out != 5'h0;
   endproperty
   a_upd: assert property (p_upd) else $error("update address wrong");

   property p_invalid;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      accept && bad_form |=> invalid_out && !mem_req_valid_out && req_ready_out;
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid form issued");

   property p_order;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      mem_req_valid_out && !mem_req_ready_in |=> mem_req_valid_out && $stable(mem_addr_out)
      && !req_ready_out;
   endproperty
   a_order: assert property (p_order) else $error("request changed while stalled");

   property p_byte_zero;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      $rose(wb_valid_out) && size_q == LAG_SZ_BYTE |-> wb_data_out[63:8] == 56'h0;
   endproperty
   a_byte_zero: assert property (p_byte_zero) else $error("byte load not cleared");

   property p_half_sign;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      $rose(wb_valid_out) && size_q == LAG_SZ_HALF && sign_q
      |-> wb_data_out[63:16] == {48{wb_data_out[15]}};
   endproperty
   a_half_sign: assert property (p_half_sign) else $error("half load not sign filled");

   property p_wrap;
      @(posedge mclk_in) disable iff (!rst_sync_n_q)
      accept && !bad_form && mode_in == LAG_MODE_IDX && base_gpr_sel_in != 5'h0
      && base_gpr_in == 32'hffff_ffff && index_gpr_in == 32'h2 |=> mem_addr_out == 32'h1;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address did not wrap");

   c_load: cover property (@(posedge mclk_in) disable iff (!rst_sync_n_q) wb_valid_out);
   c_upd_load: cover property (@(posedge mclk_in) disable iff (!rst_sync_n_q)
      wb_valid_out && upd_valid_out);
   c_store: cover property (@(posedge mclk_in) disable iff (!rst_sync_n_q)
      mem_req_valid_out && mem_req_ready_in && mem_we_out);
   c_invalid: cover property (@(posedge mclk_in) disable iff (!rst_sync_n_q) invalid_out);
endmodule : lag_top
`default_nettype wire

// [bench/lag_mem_model.sv]
// data memory partner: returns big-endian doubleword beats for loads
// assumes one request in flight; slow_in stalls ready and stretches latency
`timescale 1ns/10ps
`default_nettype none
module lag_mem_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic valid_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   output logic ready_out,
   output logic rvalid_out,
   output logic [63:0] rdata_out
);
   logic [1:0] cnt_q;
   logic [2:0] pend_q;
   logic [31:0] addr_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 2'h0;
         pend_q <= 3'h0;
         addr_q <= 32'h0;
         ready_out <= 1'b0;
         rvalid_out <= 1'b0;
         rdata_out <= 64'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         ready_out <= !slow_in || cnt_q == 2'h3;
         rvalid_out <= pend_q == 3'h1;
         // idle data bus toggles so a stale beat never looks valid
         rdata_out <= ~rdata_out;
         if (pend_q == 3'h1) begin
            for (int k = 0; k < 8; k++) begin
               rdata_out[63 - 8 * k -: 8] <= {addr_q[7:3], 3'(k)} + 8'h81;
            end
         end
         if (valid_in && ready_out && !we_in) begin
            pend_q <= slow_in ? 3'h4 : 3'h1;
            addr_q <= addr_in;
         end else if (pend_q != 3'h0) begin
            pend_q <= pend_q - 3'h1;
         end
      end
   end
endmodule : lag_mem_model
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for lag_top with a behavioural data memory
// assumes clock enable dropped only while idle; one request driven at a time
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import lag_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic slow = 1'b0;
   logic ce = 1'b1;
   logic req_valid = 1'b0;
   lag_mode_t mode = LAG_MODE_IMM;
   lag_size_t size = LAG_SZ_WORD;
   logic sgn = 1'b0, upd = 1'b0, st = 1'b0, str = 1'b0;
   logic [4:0] bsel = 5'h0, dsel = 5'h0;
   logic [15:0] disp = 16'h0;
   logic [31:0] bval = 32'h0, xval = 32'h0;
   logic [63:0] sdata = 64'h0;
   logic req_ready, mvalid, mready, mwe, rvalid, wbv, updv, inval;
   lag_size_t msize;
   logic [31:0] maddr, upd_data;
   logic [63:0] mwdata, rdata, wb_data;
   logic [4:0] wb_dest, upd_dest;
   int fail_count = 0;
   int checked = 0;
   initial forever #2 mclk_in = ~mclk_in;
   lag_top i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .req_valid_in(req_valid), .req_ready_out(req_ready), .mode_in(mode), .size_in(size),
      .sign_in(sgn), .update_in(upd), .store_in(st), .string_in(str),
      .base_gpr_sel_in(bsel), .index_gpr_sel_in(5'h3), .dest_sel_in(dsel), .disp_in(disp),
      .base_gpr_in(bval), .index_gpr_in(xval), .store_data_in(sdata),
      .mem_req_valid_out(mvalid), .mem_req_ready_in(mready), .mem_addr_out(maddr),
      .mem_size_out(msize), .mem_we_out(mwe), .mem_wdata_out(mwdata),
      .mem_rvalid_in(rvalid), .mem_rdata_in(rdata), .wb_valid_out(wbv),
      .wb_dest_out(wb_dest), .wb_data_out(wb_data), .upd_valid_out(updv),
      .upd_dest_out(upd_dest), .upd_data_out(upd_data), .invalid_out(inval));
   lag_mem_model i_mem (.clk_in(mclk_in), .rst_n_in(rst_n_in), .slow_in(slow),
      .valid_in(mvalid), .we_in(mwe), .addr_in(maddr), .ready_out(mready),
      .rvalid_out(rvalid), .rdata_out(rdata));
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask : chk
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 40) begin
         @(negedge mclk_in);
         n++;
      end
      chk(s === 1'b1, "handshake never came");
   endtask : wait_hi
   // memory byte at address a is a[7:0] + 81h, element read big-endian
   function automatic logic [63:0] exp_load(input logic [31:0] ea, input lag_size_t sz,
         input logic sg);
      logic [63:0] v;
      v = 64'h0;
      for (int i = 0; i < (1 << sz); i++) begin
         v = {v[55:0], 8'(ea[7:0] + 8'(i) + 8'h81)};
      end
      if (sz == LAG_SZ_HALF && sg && v[15]) begin
         v[63:16] = '1;
      end
      return v;
   endfunction : exp_load
   // fl is {sign, update, store, string}
   task automatic op(input lag_mode_t m, input lag_size_t sz, input logic [3:0] fl,
         input logic [4:0] bs, input logic [4:0] ds, input logic [15:0] d,
         input logic [31:0] b, input logic [31:0] x, input logic [31:0] ea);
      logic inv;
      inv = fl[2] && (bs == 5'h0 || (!fl[1] && bs == ds));
      wait_hi(req_ready);
      {sgn, upd, st, str} = fl;
      mode = m;
      size = sz;
      bsel = bs;
      dsel = ds;
      disp = d;
      bval = b;
      xval = x;
      sdata = {x, b};
      req_valid = 1'b1;
      @(negedge mclk_in);
      req_valid = 1'b0;
      if (inv) begin
         chk(inval === 1'b1 && mvalid === 1'b0, "invalid form not flagged");
         // one idle cycle so req_valid is never lowered and raised in one step
         @(negedge mclk_in);
         chk(inval === 1'b0 && mvalid === 1'b0 && req_ready === 1'b1,
             "invalid not a pulse");
         return;
      end
      chk(inval === 1'b0 && req_ready === 1'b0, "busy or invalid state wrong");
      wait_hi(mvalid);
      chk(maddr === ea && mwe === fl[1] && msize === sz, "memory request");
      if (fl[1]) begin
         chk(mwdata === sdata, "store data");
         wait_hi(req_ready);
      end else begin
         wait_hi(wbv);
         chk(wb_dest === ds && wb_data === exp_load(ea, sz, fl[3]), "load result");
      end
      chk(updv === fl[2] && (!fl[2] || (upd_dest === bs && upd_data === ea)), "update");
   endtask : op
   task automatic t_modes();
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h0, 5'h4, 5'h6, 16'hfff8, 32'h1010, 32'h77, 32'h1008);
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h0, 5'h0, 5'h6, 16'h8004, 32'hdead0000, 32'h1,
         32'hffff8004);
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h0, 5'h2, 5'h6, 16'h0008, 32'hfffffffc, 32'h0, 32'h4);
      op(LAG_MODE_IDX, LAG_SZ_DWORD, 4'h0, 5'h4, 5'h6, 16'h10, 32'hfffffff8, 32'h110,
         32'h108);
      op(LAG_MODE_IDX, LAG_SZ_WORD, 4'h0, 5'h0, 5'h6, 16'h0, 32'h55550000, 32'h204, 32'h204);
      op(LAG_MODE_IDX, LAG_SZ_WORD, 4'h1, 5'h0, 5'h6, 16'h0, 32'h55550000, 32'h204, 32'h0);
      op(LAG_MODE_IND, LAG_SZ_HALF, 4'h0, 5'h7, 5'h6, 16'h1234, 32'h302, 32'h40, 32'h302);
      op(LAG_MODE_IND, LAG_SZ_BYTE, 4'h0, 5'h0, 5'h6, 16'h1234, 32'h9, 32'h40, 32'h0);
      op(LAG_MODE_IDX, LAG_SZ_WORD, 4'h0, 5'h4, 5'h6, 16'h0, 32'hffffffff, 32'h2,
         32'h1);
      op(lag_mode_t'(2'h3), LAG_SZ_BYTE, 4'h0, 5'h7, 5'h6, 16'h0, 32'h405, 32'h0,
         32'h405);
   endtask : t_modes
   task automatic t_sizes();
      op(LAG_MODE_IMM, LAG_SZ_BYTE, 4'h8, 5'h1, 5'h9, 16'h7, 32'h100, 32'h0, 32'h107);
      op(LAG_MODE_IMM, LAG_SZ_HALF, 4'h8, 5'h1, 5'h9, 16'h2, 32'h100, 32'h0, 32'h102);
      op(LAG_MODE_IMM, LAG_SZ_HALF, 4'h0, 5'h1, 5'h9, 16'h2, 32'h100, 32'h0, 32'h102);
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h8, 5'h1, 5'h9, 16'h4, 32'h180, 32'h0, 32'h184);
      op(LAG_MODE_IMM, LAG_SZ_DWORD, 4'h8, 5'h1, 5'h9, 16'h8, 32'h180, 32'h0, 32'h188);
   endtask : t_sizes
   task automatic t_update();
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h4, 5'h5, 5'h6, 16'h10, 32'h2000, 32'h0, 32'h2010);
      op(LAG_MODE_IDX, LAG_SZ_BYTE, 4'h4, 5'h5, 5'h6, 16'h0, 32'h2000, 32'h33, 32'h2033);
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h4, 5'h0, 5'h6, 16'h10, 32'h2000, 32'h0, 32'h10);
      op(LAG_MODE_IDX, LAG_SZ_WORD, 4'h4, 5'h6, 5'h6, 16'h0, 32'h2000, 32'h4, 32'h2004);
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h6, 5'h0, 5'h6, 16'h10, 32'h2000, 32'h0, 32'h10);
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h6, 5'h6, 5'h6, 16'h10, 32'h2000, 32'h0, 32'h2010);
      op(LAG_MODE_IMM, LAG_SZ_HALF, 4'h0, 5'h5, 5'h6, 16'h2, 32'h2000, 32'h0, 32'h2002);
   endtask : t_update
   // frozen clock enable: a waiting request is held off, then taken once released
   task automatic t_hold();
      wait_hi(req_ready);
      ce = 1'b0;
      {sgn, upd, st, str} = 4'h4;
      bsel = 5'h0;
      req_valid = 1'b1;
      repeat (3) @(negedge mclk_in);
      chk(mvalid === 1'b0 && inval === 1'b0 && req_ready === 1'b1,
          "taken while frozen");
      ce = 1'b1;
      @(negedge mclk_in);
      req_valid = 1'b0;
      chk(inval === 1'b1 && mvalid === 1'b0, "invalid lost after freeze");
      @(negedge mclk_in);
   endtask : t_hold
   // slow memory: each access must still leave in the order it was issued
   task automatic t_order();
      slow = 1'b1;
      op(LAG_MODE_IMM, LAG_SZ_WORD, 4'h0, 5'h1, 5'h2, 16'h0, 32'h3000, 32'h0, 32'h3000);
      op(LAG_MODE_IMM, LAG_SZ_DWORD, 4'h2, 5'h1, 5'h2, 16'h8, 32'h3000, 32'h9, 32'h3008);
      op(LAG_MODE_IDX, LAG_SZ_HALF, 4'h8, 5'h1, 5'h2, 16'h0, 32'h3000, 32'h6, 32'h3006);
      slow = 1'b0;
   endtask : t_order
   // roughly 25 transfers of under 20 cycles each; the limit leaves wide margin
   initial begin
      #20000;
      fail_count++;
      close_out();
   end
   initial begin
      repeat (10) @(negedge mclk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      t_modes();
      t_sizes();
      t_update();
      t_hold();
      t_order();
      repeat (4) @(negedge mclk_in);
      close_out();
   end
endmodule : testbench
`default_nettype wire
